/* bcs_map.vh */
`ifndef BCS_MAP_VH
`define BCS_MAP_VH

`define BCS_ADDR_STATUS    8'h00
`define BCS_ADDR_CTRL      8'h04
`define BCS_ADDR_IRQ_STS   8'h08
`define BCS_ADDR_IRQ_MASK  8'h0C

`define BCS_STS_DONE       0
`define BCS_STS_FAIL       1
`define BCS_STS_SEL_LO     2
`define BCS_STS_SEL_HI     4
`define BCS_STS_EFF_LO     5
`define BCS_STS_EFF_HI     7
`define BCS_STS_CMP        8
`define BCS_STS_W          16
`define BCS_RESET_STS      16'h0000

`define BCS_CTRL_START     0
`define BCS_CTRL_EFF_OVR   1
`define BCS_CTRL_OVR_LO    4
`define BCS_CTRL_OVR_HI    6

`define BCS_IRQ_DONE       0
`define BCS_IRQ_FAIL       1

`define BCS_TRIM_W         3
`define BCS_TRIM_MAX       3'h7
`define BCS_TRIM_ZERO      3'h0
`define BCS_SETTLE_CYC     4'hF
`define BCS_RESP_OKAY      2'h0
`define BCS_RESP_SLVERR    2'h2

`endif

/* bcs_bias_cal_status.v */
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.vh"

module bcs_bias_cal_status (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        bias_cmp_in,
    output reg  [2:0]  bias_trim_out,
    output reg         irq
);

localparam ST_IDLE   = 2'd0;
localparam ST_SETTLE = 2'd1;
localparam ST_SAMPLE = 2'd2;
localparam ST_DONE   = 2'd3;

// comparator pin is asynchronous to aclk
reg        cmp_meta_reg;
reg        cmp_sync_reg;
reg [1:0]  state_reg;
reg [3:0]  settle_reg;
reg [2:0]  trial_reg;
reg [2:0]  sel_reg;
reg        fail_reg;
reg        done_reg;
reg [2:0]  ctrl_ovr_reg;
reg        ctrl_ovr_en_reg;
reg [1:0]  irq_sts_reg;
reg [1:0]  irq_mask_reg;
reg [7:0]  awaddr_reg;
reg [31:0] wdata_reg;
reg [3:0]  wstrb_reg;
reg        aw_held_reg;
reg        w_held_reg;

wire [2:0] eff_trim = ctrl_ovr_en_reg ? ctrl_ovr_reg : sel_reg;

reg [`BCS_STS_W-1:0] status_word;
reg [31:0]           ctrl_word;
reg [31:0]           irq_sts_word;
reg [31:0]           irq_mask_word;
reg [31:0]           rdata_next;
reg [1:0]            rresp_next;
reg [1:0]            bresp_next;
reg [1:0]            irq_set;

// fields land at named positions over the all-zero default, so reserved bits read low
always @* begin
    status_word                                  = `BCS_RESET_STS;
    status_word[`BCS_STS_DONE]                   = done_reg;
    status_word[`BCS_STS_FAIL]                   = fail_reg;
    status_word[`BCS_STS_SEL_HI:`BCS_STS_SEL_LO] = sel_reg;
    status_word[`BCS_STS_EFF_HI:`BCS_STS_EFF_LO] = eff_trim;
    status_word[`BCS_STS_CMP]                    = cmp_sync_reg;
end

// readback of the writable registers; start is a strobe and reads low
always @* begin
    ctrl_word                                    = 32'h00000000;
    ctrl_word[`BCS_CTRL_EFF_OVR]                 = ctrl_ovr_en_reg;
    ctrl_word[`BCS_CTRL_OVR_HI:`BCS_CTRL_OVR_LO] = ctrl_ovr_reg;
    irq_sts_word                                 = 32'h00000000;
    irq_sts_word[`BCS_IRQ_DONE]                  = irq_sts_reg[`BCS_IRQ_DONE];
    irq_sts_word[`BCS_IRQ_FAIL]                  = irq_sts_reg[`BCS_IRQ_FAIL];
    irq_mask_word                                = 32'h00000000;
    irq_mask_word[`BCS_IRQ_DONE]                 = irq_mask_reg[`BCS_IRQ_DONE];
    irq_mask_word[`BCS_IRQ_FAIL]                 = irq_mask_reg[`BCS_IRQ_FAIL];
end

always @(posedge aclk) begin
    if (!aresetn) begin
        cmp_meta_reg <= 1'b0;
        cmp_sync_reg <= 1'b0;
    end else begin
        cmp_meta_reg <= bias_cmp_in;
        cmp_sync_reg <= cmp_meta_reg;
    end
end

wire write_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
wire start_wr   = write_fire && (awaddr_reg == `BCS_ADDR_CTRL) && wstrb_reg[0] && wdata_reg[`BCS_CTRL_START];

// calibration: linear trim search, first setting where the comparator trips wins
always @(posedge aclk) begin
    if (!aresetn) begin
        state_reg  <= ST_SETTLE;
        settle_reg <= `BCS_SETTLE_CYC;
        trial_reg  <= `BCS_TRIM_ZERO;
        sel_reg    <= `BCS_TRIM_ZERO;
        fail_reg   <= 1'b0;
        done_reg   <= 1'b0;
    end else begin
        case (state_reg)
            ST_IDLE: begin
                if (start_wr) begin
                    done_reg   <= 1'b0;
                    trial_reg  <= `BCS_TRIM_ZERO;
                    settle_reg <= `BCS_SETTLE_CYC;
                    state_reg  <= ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                // wait covers analog settling plus the two sync stages
                if (settle_reg == 4'h0) begin
                    state_reg <= ST_SAMPLE;
                end else begin
                    settle_reg <= settle_reg - 4'h1;
                end
            end
            ST_SAMPLE: begin
                if (cmp_sync_reg) begin
                    sel_reg   <= trial_reg;
                    fail_reg  <= 1'b0;
                    done_reg  <= 1'b1;
                    state_reg <= ST_DONE;
                end else if (trial_reg == `BCS_TRIM_MAX) begin
                    sel_reg   <= `BCS_TRIM_MAX;
                    fail_reg  <= 1'b1;
                    done_reg  <= 1'b1;
                    state_reg <= ST_DONE;
                end else begin
                    trial_reg  <= trial_reg + 3'h1;
                    settle_reg <= `BCS_SETTLE_CYC;
                    state_reg  <= ST_SETTLE;
                end
            end
            ST_DONE: begin
                state_reg <= ST_IDLE;
            end
            default: begin
                state_reg <= ST_IDLE;
            end
        endcase
    end
end

// during the search the trial value drives the circuit, afterwards the effective one
always @(posedge aclk) begin
    if (!aresetn) begin
        bias_trim_out <= `BCS_TRIM_ZERO;
    end else if (state_reg == ST_SETTLE || state_reg == ST_SAMPLE) begin
        bias_trim_out <= trial_reg;
    end else begin
        bias_trim_out <= eff_trim;
    end
end

wire done_rise = (state_reg == ST_SAMPLE) && (cmp_sync_reg || trial_reg == `BCS_TRIM_MAX);
wire fail_rise = (state_reg == ST_SAMPLE) && !cmp_sync_reg && trial_reg == `BCS_TRIM_MAX;
wire irq_wr    = write_fire && (awaddr_reg == `BCS_ADDR_IRQ_STS) && wstrb_reg[0];
wire mask_wr   = write_fire && (awaddr_reg == `BCS_ADDR_IRQ_MASK) && wstrb_reg[0];
wire ctrl_wr   = write_fire && (awaddr_reg == `BCS_ADDR_CTRL) && wstrb_reg[0];
always @* begin
    irq_set                = 2'h0;
    irq_set[`BCS_IRQ_DONE] = done_rise;
    irq_set[`BCS_IRQ_FAIL] = fail_rise;
end
wire [1:0] irq_clr = irq_wr ? wdata_reg[1:0] : 2'h0;

genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq
        // set wins over a simultaneous write-one-to-clear
        always @(posedge aclk) begin
            if (!aresetn) begin
                irq_sts_reg[gi] <= 1'b0;
            end else if (irq_set[gi]) begin
                irq_sts_reg[gi] <= 1'b1;
            end else if (irq_clr[gi]) begin
                irq_sts_reg[gi] <= 1'b0;
            end
        end
    end
endgenerate

always @(posedge aclk) begin
    if (!aresetn) begin
        irq_mask_reg    <= 2'h0;
        ctrl_ovr_en_reg <= 1'b0;
        ctrl_ovr_reg    <= `BCS_TRIM_ZERO;
        irq             <= 1'b0;
    end else begin
        if (mask_wr) begin
            irq_mask_reg <= wdata_reg[1:0];
        end
        // override only changes the applied trim, the chosen trim stays visible
        if (ctrl_wr) begin
            ctrl_ovr_en_reg <= wdata_reg[`BCS_CTRL_EFF_OVR];
            ctrl_ovr_reg    <= wdata_reg[`BCS_CTRL_OVR_HI:`BCS_CTRL_OVR_LO];
        end
        irq <= |(irq_sts_reg & irq_mask_reg);
    end
end

// status word is read-only: writes to it and to holes are refused
always @* begin
    case (awaddr_reg)
        `BCS_ADDR_CTRL:     bresp_next = `BCS_RESP_OKAY;
        `BCS_ADDR_IRQ_STS:  bresp_next = `BCS_RESP_OKAY;
        `BCS_ADDR_IRQ_MASK: bresp_next = `BCS_RESP_OKAY;
        default:            bresp_next = `BCS_RESP_SLVERR;
    endcase
end

// write channel: address and data accepted in either order, one write at a time
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held_reg   <= 1'b0;
        w_held_reg    <= 1'b0;
        awaddr_reg    <= 8'h00;
        wdata_reg     <= 32'h00000000;
        wstrb_reg     <= 4'h0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `BCS_RESP_OKAY;
    end else begin
        s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
        s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end
        if (write_fire) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= bresp_next;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// read decode; araddr is held by the master until the handshake edge
always @* begin
    rdata_next = 32'h00000000;
    rresp_next = `BCS_RESP_OKAY;
    case (s_axi_araddr)
        `BCS_ADDR_STATUS: begin
            rdata_next = {16'h0000, status_word};
        end
        `BCS_ADDR_CTRL: begin
            rdata_next = ctrl_word;
        end
        `BCS_ADDR_IRQ_STS: begin
            rdata_next = irq_sts_word;
        end
        `BCS_ADDR_IRQ_MASK: begin
            rdata_next = irq_mask_word;
        end
        default: begin
            rresp_next = `BCS_RESP_SLVERR;
        end
    endcase
end

// read channel
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h00000000;
        s_axi_rresp   <= `BCS_RESP_OKAY;
    end else begin
        s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rresp_next;
            s_axi_rdata  <= rdata_next;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule
`default_nettype wire

/* bcs_bias_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bcs_bias_model (
    input  wire logic [2:0] trim,
    input  wire logic [3:0] thr,
    output var  logic       trip
);
    // ideal comparator: trips once the applied trim reaches the threshold
    // a threshold of 8 never trips, which forces a failed search
    always_comb trip = ({1'b0, trim} >= thr);
endmodule
`default_nettype wire

/* bcs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.vh"
module bcs_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic [2:0]  bias_trim_out
);
    logic rd_sts_reg;
    logic rd_bad_reg;
    logic wr_sts_reg;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // remember whether each response belongs to the status word, and whether a read hit an unmapped address
    always @(posedge aclk) begin
        if (!aresetn) begin
            rd_sts_reg <= 1'b0;
            rd_bad_reg <= 1'b0;
            wr_sts_reg <= 1'b0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                rd_sts_reg <= (s_axi_araddr == `BCS_ADDR_STATUS);
                rd_bad_reg <= (s_axi_araddr > `BCS_ADDR_IRQ_MASK) || (s_axi_araddr[1:0] != 2'h0);
            end
            if (s_axi_awvalid && s_axi_awready) begin
                wr_sts_reg <= (s_axi_awaddr == `BCS_ADDR_STATUS);
            end
        end
    end
    property p_rd_upper_zero; s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h0; endproperty
    a_rd_upper_zero: assert property (p_rd_upper_zero) else $error("read data above bit 8 not zero");
    property p_wr_sts_err; s_axi_bvalid && wr_sts_reg |-> s_axi_bresp == `BCS_RESP_SLVERR; endproperty
    a_wr_sts_err: assert property (p_wr_sts_err) else $error("status write not refused");
    property p_rd_sts_ok; s_axi_rvalid && rd_sts_reg |-> s_axi_rresp == `BCS_RESP_OKAY; endproperty
    a_rd_sts_ok: assert property (p_rd_sts_ok) else $error("status read refused");
    property p_eff_out; s_axi_rvalid && rd_sts_reg && s_axi_rdata[0] |-> s_axi_rdata[7:5] == bias_trim_out; endproperty
    a_eff_out: assert property (p_eff_out) else $error("effective trim differs from trim output");
    property p_fail_max; s_axi_rvalid && rd_sts_reg && s_axi_rdata[1:0] == 2'h3 |-> s_axi_rdata[4:2] == 3'h7; endproperty
    a_fail_max: assert property (p_fail_max) else $error("failed search not ending at top trim");
    // each trial holds the trim so the comparator can settle
    property p_trim_settle; $changed(bias_trim_out) |=> $stable(bias_trim_out) [*8]; endproperty
    a_trim_settle: assert property (p_trim_settle) else $error("trim output changed too soon");
    property p_rd_bad; s_axi_rvalid && rd_bad_reg |-> s_axi_rresp == `BCS_RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
    a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not refused");
    c_pass: cover property (s_axi_rvalid && rd_sts_reg && s_axi_rdata[1:0] == 2'h1);
    c_fail: cover property (s_axi_rvalid && rd_sts_reg && s_axi_rdata[1:0] == 2'h3);
    c_wr_err: cover property (s_axi_bvalid && wr_sts_reg);
endmodule
bind bcs_bias_cal_status bcs_monitor u_mon (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .bias_trim_out(bias_trim_out));
`default_nettype wire

/* bcs_bias_cal_status_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.vh"
module bcs_bias_cal_status_tb_top;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, bias_cmp_in, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
    logic [3:0]  s_axi_wstrb, cmp_thr;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [2:0]  bias_trim_out;
    int          bad_count = 0;
    int          total_checks = 0;
    always #5 aclk = ~aclk;
    bcs_bias_cal_status dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .bias_cmp_in(bias_cmp_in), .bias_trim_out(bias_trim_out), .irq(irq));
    bcs_bias_model u_model (.trim(bias_trim_out), .thr(cmp_thr), .trip(bias_cmp_in));
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd_val = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // poll the status word; a search over all eight trims takes well under 99 reads
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            axi_rd(`BCS_ADDR_STATUS);
            n++;
        end while (rd_val[0] !== 1'b1 && n < 99);
    endtask
    task automatic report_and_stop;
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge aclk);
        bad_count++;
        report_and_stop();
    end
    initial begin
        aclk = 1'b0;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        cmp_thr = 4'h3;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(`BCS_ADDR_STATUS);
        check("sts_running", rd_val & 32'hFFFF_FE01, 32'h0);
        wait_done();
        check("sts_pass", rd_val, 32'h0000_016D);
        axi_wr(`BCS_ADDR_STATUS, 32'h0000_FFFF);
        check("sts_wr_resp", rsp, `BCS_RESP_SLVERR);
        axi_rd(`BCS_ADDR_STATUS);
        check("sts_ro", rd_val, 32'h0000_016D);
        axi_rd(8'h10);
        check("unmapped", {rd_val[29:0], rsp}, {30'h0, `BCS_RESP_SLVERR});
        axi_wr(`BCS_ADDR_CTRL, 32'h0000_0052);
        check("ctrl_wr_resp", rsp, `BCS_RESP_OKAY);
        axi_rd(`BCS_ADDR_CTRL);
        check("ctrl_rd", rd_val, 32'h0000_0052);
        axi_rd(`BCS_ADDR_STATUS);
        check("sts_ovr", rd_val, 32'h0000_01AD);
        check("trim_ovr", bias_trim_out, 32'h5);
        cmp_thr <= 4'h8;
        repeat (4) @(posedge aclk);
        axi_rd(`BCS_ADDR_STATUS);
        check("sts_cmp_low", rd_val, 32'h0000_00AD);
        axi_wr(`BCS_ADDR_CTRL, 32'h0000_0001);
        axi_rd(`BCS_ADDR_STATUS);
        check("sts_rerun", rd_val[0], 32'h0);
        wait_done();
        check("sts_fail", rd_val, 32'h0000_00FF);
        check("irq_masked", irq, 32'h0);
        axi_rd(`BCS_ADDR_IRQ_STS);
        check("irq_sts", rd_val, 32'h3);
        axi_wr(`BCS_ADDR_IRQ_MASK, 32'h2);
        repeat (3) @(posedge aclk);
        check("irq_on", irq, 32'h1);
        axi_rd(`BCS_ADDR_IRQ_MASK);
        check("irq_mask_rd", rd_val, 32'h2);
        axi_wr(`BCS_ADDR_IRQ_STS, 32'h2);
        repeat (3) @(posedge aclk);
        check("irq_off", irq, 32'h0);
        axi_rd(`BCS_ADDR_IRQ_STS);
        check("irq_w1c", rd_val, 32'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
